/* hw/touch_probe_position_capture.sv */
// Touch probe position capture with one-shot execute handshake.
// Assumes execute, abort and parameters come from logic on clk_i; pins are synchronised here.
`default_nettype none
module touch_probe_position_capture
  import capture_pkg::*;
#(
  parameter int TASK_DIV = TASK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic execute_i,
  input wire logic [3:0] mode_i,
  input wire logic [3:0] trigger_select_i,
  input wire logic preempt_i,
  input wire logic axis_alarm_i,
  input wire logic axis_offline_i,
  // Gear parameters
  input wire logic [31:0] out_rot_i,
  input wire logic [31:0] units_per_rot_i,
  input wire logic [31:0] in_rot_i,
  input wire logic [31:0] pulses_per_rot_i,
  // Trigger pins
  input wire logic [15:0] ctrl_inputs_i,
  input wire logic drive_probe_input_i,
  input wire logic index_pulse_i,
  // Raw counts
  input wire logic [31:0] ext_encoder_count_i,
  input wire logic [31:0] motor_feedback_count_i,
  // Status
  output logic done_o,
  output logic busy_o,
  output logic active_o,
  output logic aborted_o,
  output logic error_o,
  output logic [15:0] fault_code_o,
  output logic signed [POS_W-1:0] captured_position_o,
  output logic signed [POS_W-1:0] trailing_edge_capture_o
);
  // Divider counter is only DIV_W bits wide
  if (TASK_DIV < 1 || TASK_DIV > 65535) begin : g_div_check
    $error("TASK_DIV out of range");
  end

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ARM = 2'b01,
    S_RUN = 2'b10,
    S_HOLD = 2'b11
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [DIV_W-1:0] div;
    logic [17:0] sync_in1, sync_in2;
    logic trig_prev;
    logic exec_prev;
    logic done, busy, active, aborted, error, pulse_clr;
    logic [15:0] fault;
    logic [31:0] ext_prev, mot_prev;
    logic signed [POS_W-1:0] ext_acc, mot_acc;
    logic falling_pending;
    logic signed [POS_W-1:0] cap_pos, trail_pos;
  } st_t;
  st_t st_r, st_nxt;

  logic tick;
  logic [17:0] pin_raw;
  logic sel_in;
  logic trig_lvl;
  logic rise, fall;
  logic mode_ok;
  logic drive_mode;
  logic scale_start;
  logic signed [POS_W-1:0] scale_src;
  logic scale_done;
  logic signed [POS_W-1:0] scale_pos;

  assign pin_raw = {index_pulse_i, drive_probe_input_i, ctrl_inputs_i};

  assign tick = (st_r.div == DIV_W'(TASK_DIV - 1));
  assign sel_in = st_r.sync_in2[trigger_select_i]; // see RULE_20
  assign drive_mode = (mode_i == MODE_DRV_RISE) || (mode_i == MODE_DRV_FALL)
                      || (mode_i == MODE_DRV_BOTH) || (mode_i == MODE_INDEX);
  assign mode_ok = drive_mode || (mode_i == MODE_IN_RISE) || (mode_i == MODE_IN_FALL);

  always_comb begin
    unique case (mode_i)
      MODE_IN_RISE, MODE_IN_FALL: trig_lvl = sel_in;
      MODE_INDEX: trig_lvl = st_r.sync_in2[17]; // see RULE_19
      default: trig_lvl = st_r.sync_in2[16];
    endcase
  end

  // Edges judged once per task period, sampled at the period tick
  assign rise = trig_lvl && !st_r.trig_prev; // see RULE_15
  assign fall = !trig_lvl && st_r.trig_prev;

  assign scale_src = drive_mode ? st_r.mot_acc : st_r.ext_acc; // see RULE_11 RULE_12

  position_scaler u_scaler (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(scale_start),
    .pulses_i(scale_src),
    .out_rot_i(out_rot_i),
    .units_per_rot_i(units_per_rot_i),
    .in_rot_i(in_rot_i),
    .pulses_per_rot_i(pulses_per_rot_i),
    .done_o(scale_done),
    .pos_o(scale_pos)
  );

  always_comb begin
    logic hit, hit_fall, exec_fell;
    hit = 1'b0;
    hit_fall = 1'b0;
    exec_fell = 1'b0;
    st_nxt = st_r;
    scale_start = 1'b0;
    st_nxt.div = tick ? '0 : st_r.div + DIV_W'(1);
    // Two-stage synchroniser; first stage feeds only the second
    st_nxt.sync_in1 = pin_raw;
    st_nxt.sync_in2 = st_r.sync_in1;

    // Unwrap the 32-bit counts so position grows across the wrap
    st_nxt.ext_prev = ext_encoder_count_i;
    st_nxt.mot_prev = motor_feedback_count_i;
    st_nxt.ext_acc = st_r.ext_acc
      + POS_W'($signed(ext_encoder_count_i - st_r.ext_prev)); // see RULE_13
    st_nxt.mot_acc = st_r.mot_acc
      + POS_W'($signed(motor_feedback_count_i - st_r.mot_prev)); // see RULE_13

    // Falling edge result of mode 7 arrives from the scaler a cycle later
    if (scale_done) begin
      if (st_r.falling_pending) begin
        st_nxt.trail_pos = scale_pos; // see RULE_18
      end else begin
        st_nxt.cap_pos = scale_pos; // see RULE_21
      end
    end

    if (tick) begin
      st_nxt.trig_prev = trig_lvl;
      st_nxt.exec_prev = execute_i;
      exec_fell = st_r.exec_prev && !execute_i;
      if (st_r.pulse_clr) begin
        st_nxt.done = 1'b0; // see RULE_10
        st_nxt.aborted = 1'b0; // see RULE_07
        st_nxt.pulse_clr = 1'b0;
      end
      if (exec_fell) begin
        st_nxt.done = 1'b0; // see RULE_03
        st_nxt.aborted = 1'b0; // see RULE_06
        st_nxt.error = 1'b0; // see RULE_08
        st_nxt.fault = FAULT_NONE;
      end
      unique case (mode_i)
        MODE_IN_RISE, MODE_DRV_RISE, MODE_INDEX: hit = rise; // see RULE_16 RULE_17
        MODE_IN_FALL, MODE_DRV_FALL: hit = fall; // see RULE_16 RULE_17
        MODE_DRV_BOTH: begin
          hit = rise || fall;
          hit_fall = fall; // see RULE_18
        end
        default: hit = 1'b0;
      endcase

      unique case (st_r.phase)
        S_IDLE, S_HOLD: begin
          if (execute_i && !st_r.exec_prev) begin
            st_nxt.done = 1'b0;
            st_nxt.aborted = 1'b0;
            st_nxt.pulse_clr = 1'b0;
            if (!mode_ok) begin
              st_nxt.error = 1'b1; // see RULE_22
              st_nxt.fault = FAULT_BAD_MODE; // see RULE_09
              st_nxt.phase = S_HOLD;
            end else begin
              st_nxt.error = 1'b0;
              st_nxt.fault = FAULT_NONE;
              st_nxt.busy = 1'b1; // see RULE_04
              st_nxt.phase = S_ARM;
            end
          end
        end
        S_ARM, S_RUN: begin
          if (st_r.phase == S_ARM) begin
            st_nxt.active = 1'b1; // see RULE_04
            st_nxt.phase = S_RUN;
          end
          if (preempt_i) begin
            st_nxt.aborted = 1'b1; // see RULE_06
            st_nxt.pulse_clr = !execute_i; // see RULE_07
          end else if (axis_alarm_i || axis_offline_i) begin
            st_nxt.error = 1'b1; // see RULE_08
            st_nxt.fault = axis_alarm_i ? FAULT_AXIS_ALARM : FAULT_AXIS_OFFLINE; // see RULE_09
          end else if (hit && st_r.phase == S_RUN) begin
            scale_start = 1'b1;
            st_nxt.falling_pending = hit_fall;
            // Mode 7 stays armed until its falling edge has been taken
            if (mode_i != MODE_DRV_BOTH || hit_fall) begin
              st_nxt.done = 1'b1; // see RULE_03
              st_nxt.pulse_clr = !execute_i; // see RULE_10
            end
          end
          if (st_nxt.done || st_nxt.error || st_nxt.aborted) begin
            st_nxt.busy = 1'b0; // see RULE_05
            st_nxt.active = 1'b0; // see RULE_05
            st_nxt.phase = S_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
  assign busy_o = st_r.busy;
  assign active_o = st_r.active;
  assign aborted_o = st_r.aborted;
  assign error_o = st_r.error;
  assign fault_code_o = st_r.fault;
  assign captured_position_o = st_r.cap_pos;
  assign trailing_edge_capture_o = st_r.trail_pos;
endmodule : touch_probe_position_capture
`default_nettype wire

/* hw/capture_pkg.sv */
// Constants for the position capture block.
// Assumes a single 250 MHz clock; task period is an enable pulse from a divider.
// Notes on behaviour
// RULE_01 - Requester avoids concurrent captures on one input point
// RULE_02 - Requester avoids concurrent drive captures per axis
// RULE_03 - Done on capture, cleared when execute falls
// RULE_04 - Busy first period, active one period later
// RULE_05 - Busy and active drop with done/error/abort
// RULE_06 - Abort on preemption, cleared when execute falls
// RULE_07 - Late abort after execute fell: one period
// RULE_08 - Error on failure or illegal parameters
// RULE_09 - Fault code shown with error flag
// RULE_10 - Late completion: done pulses one period
// RULE_11 - Modes 0,1 use external encoder count
// RULE_12 - Modes 5-8 use motor feedback count
// RULE_13 - Position keeps counting across raw wrap
// RULE_14 - Position is raw times gear ratio quotient
// RULE_15 - One capture per selected trigger edge
// RULE_16 - Mode 0 rising, mode 1 falling input
// RULE_17 - Mode 5 rising, mode 6 falling probe
// RULE_18 - Mode 7 both edges, falling separately output
// RULE_19 - Mode 8 captures on index rising edge
// RULE_20 - Input select 0-15 used in modes 0,1
// RULE_21 - Captured position kept after execute falls
// RULE_22 - Other mode values raise error
`default_nettype none
package capture_pkg;
  localparam logic [3:0] MODE_IN_RISE = 4'h0;
  localparam logic [3:0] MODE_IN_FALL = 4'h1;
  localparam logic [3:0] MODE_DRV_RISE = 4'h5;
  localparam logic [3:0] MODE_DRV_FALL = 4'h6;
  localparam logic [3:0] MODE_DRV_BOTH = 4'h7;
  localparam logic [3:0] MODE_INDEX = 4'h8;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_BAD_MODE = 16'h0001;
  localparam logic [15:0] FAULT_AXIS_ALARM = 16'h0002;
  localparam logic [15:0] FAULT_AXIS_OFFLINE = 16'h0003;
  localparam int CLK_MHZ = 250;
  localparam int TASK_PERIOD_US = 1;
  localparam int TASK_CYCLES = CLK_MHZ * TASK_PERIOD_US;
  localparam int DIV_W = 16;
  localparam int POS_W = 64;
  localparam int MUL_W = 96;
endpackage : capture_pkg
`default_nettype wire

/* hw/position_scaler.sv */
// Scales an unwrapped pulse count into axis units.
// Assumes gear parameters are stable while a result is awaited.
`default_nettype none
module position_scaler
  import capture_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic start_i,
  input wire logic signed [POS_W-1:0] pulses_i,
  input wire logic [31:0] out_rot_i,
  input wire logic [31:0] units_per_rot_i,
  input wire logic [31:0] in_rot_i,
  input wire logic [31:0] pulses_per_rot_i,
  // Result
  output logic done_o,
  output logic signed [POS_W-1:0] pos_o
);
  typedef struct packed {
    logic done;
    logic signed [POS_W-1:0] pos;
  } st_t;
  st_t st_r, st_nxt;
  logic signed [MUL_W-1:0] num;
  logic signed [MUL_W-1:0] den;

  always_comb begin
    // One-cycle combinational divide; fine for a slow task-period result
    num = MUL_W'(pulses_i) * MUL_W'($signed({1'b0, out_rot_i}))
          * MUL_W'($signed({1'b0, units_per_rot_i})); // see RULE_14
    den = MUL_W'($signed({1'b0, in_rot_i})) * MUL_W'($signed({1'b0, pulses_per_rot_i}));
    st_nxt = st_r;
    st_nxt.done = start_i;
    if (start_i && den != '0) begin
      st_nxt.pos = POS_W'(num / den); // see RULE_14
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
  assign pos_o = st_r.pos;
endmodule : position_scaler
`default_nettype wire

/* verif/capture_checker.sv */
// Port checker for the capture handshake.
// Assumes inputs change on the falling clock edge.
`default_nettype none
module capture_checker
  import capture_pkg::*;
#(
  parameter int TASK_DIV = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic execute_i,
  input wire logic [3:0] mode_i,
  input wire logic preempt_i,
  input wire logic axis_alarm_i,
  // Status
  input wire logic done_o,
  input wire logic busy_o,
  input wire logic active_o,
  input wire logic aborted_o,
  input wire logic error_o,
  input wire logic [15:0] fault_code_o,
  input wire logic signed [POS_W-1:0] captured_position_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic idle, legal;
  assign idle = !(busy_o | done_o | error_o | aborted_o | preempt_i | axis_alarm_i);
  assign legal = mode_i inside {4'h0, 4'h1, [4'h5:4'h8]};
  property p_go; $rose(execute_i) && idle && legal |-> ##[1:6] busy_o; endproperty
  a_go: assert property (p_go) else $error("busy late");
  property p_drop; $rose(done_o) || $rose(error_o) || $rose(aborted_o) |-> !busy_o && !active_o;
  endproperty
  a_drop: assert property (p_drop) else $error("busy kept");
  property p_dhold; done_o && execute_i |=> done_o; endproperty
  a_dhold: assert property (p_dhold) else $error("done lost");
  property p_ehold; error_o && execute_i |=> error_o; endproperty
  a_ehold: assert property (p_ehold) else $error("error lost");
  property p_bad; $rose(execute_i) && idle && !legal |-> ##[1:6] error_o && fault_code_o == 16'h0001;
  endproperty
  a_bad: assert property (p_bad) else $error("mode accepted");
  property p_kept; $fell(done_o) |-> $stable(captured_position_o); endproperty
  a_kept: assert property (p_kept) else $error("position lost");
  property p_abt; busy_o && preempt_i |-> ##[1:6] aborted_o; endproperty
  a_abt: assert property (p_abt) else $error("no abort");
  property p_late; $rose(done_o) && !execute_i |-> ##[1:8] !done_o; endproperty
  a_late: assert property (p_late) else $error("done stuck");
endmodule : capture_checker
bind touch_probe_position_capture capture_checker #(.TASK_DIV(TASK_DIV)) u_chk (.clk_i, .nrst_i,
  .execute_i, .mode_i, .preempt_i, .axis_alarm_i, .done_o, .busy_o, .active_o, .aborted_o,
  .error_o, .fault_code_o, .captured_position_o);
`default_nettype wire

/* verif/far_side_model.sv */
// Encoder counters seen by the capture block.
// Assumes the bench sets count values on the falling edge.
`default_nettype none
module far_side_model (
  // Clock
  input wire logic clk_i,
  // Bench values
  input wire logic [31:0] ext_set_i,
  input wire logic [31:0] motor_set_i,
  // Counts
  output logic [31:0] ext_encoder_count_o,
  output logic [31:0] motor_feedback_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    ext_encoder_count_o <= ext_set_i;
    motor_feedback_count_o <= motor_set_i;
  end
endmodule : far_side_model
`default_nettype wire

/* verif/touch_probe_position_capture_tb.sv */
// Bench for the position capture block.
// Assumes a 4-clock task period and gear 3 x 1000 / (2 x 10000).
`default_nettype none
module touch_probe_position_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  typedef struct {logic [3:0] m; logic [3:0] s; logic lv;} row_t;
  row_t rows[6] = '{'{4'h0, 4'h0, 1'b0}, '{4'h1, 4'hF, 1'b1}, '{4'h0, 4'h9, 1'b0},
    '{4'h5, 4'h0, 1'b0}, '{4'h6, 4'h0, 1'b1}, '{4'h8, 4'h0, 1'b0}};
  logic clk = 1'b0, nrst = 1'b0, exe = 1'b0, pre = 1'b0, alm = 1'b0, off = 1'b0;
  logic prb = 1'b0, idx = 1'b0;
  logic [3:0] mode = 4'h0, sel = 4'h0;
  logic [15:0] ctrl = 16'h0000;
  logic [31:0] ext = 32'h0000027E, mot = 32'h000001B3;
  wire [31:0] ext_w, mot_w;
  wire done, busy, act, abt, err;
  wire [15:0] fault;
  wire signed [63:0] pos, tpos;
  wire [15:0] st = {11'h000, done, busy, act, abt, err};
  int bad_count = 0, check_count = 0;
  always #2 clk = ~clk;
  far_side_model u_far (.clk_i(clk), .ext_set_i(ext), .motor_set_i(mot),
    .ext_encoder_count_o(ext_w), .motor_feedback_count_o(mot_w));
  touch_probe_position_capture #(.TASK_DIV(4)) u_dut (.clk_i(clk), .nrst_i(nrst),
    .execute_i(exe), .mode_i(mode), .trigger_select_i(sel), .preempt_i(pre),
    .axis_alarm_i(alm), .axis_offline_i(off), .out_rot_i(32'h3), .units_per_rot_i(32'h3E8),
    .in_rot_i(32'h2), .pulses_per_rot_i(32'h2710), .ctrl_inputs_i(ctrl),
    .drive_probe_input_i(prb), .index_pulse_i(idx), .ext_encoder_count_i(ext_w),
    .motor_feedback_count_i(mot_w), .done_o(done), .busy_o(busy), .active_o(act),
    .aborted_o(abt), .error_o(err), .fault_code_o(fault), .captured_position_o(pos),
    .trailing_edge_capture_o(tpos));
  function automatic logic signed [63:0] scale(input logic [31:0] c);
    return 64'(c) * 64'h0BB8 / 64'h4E20;
  endfunction : scale
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk_flags(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk_flags
  task automatic chk_pos(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk_pos
  task automatic pin(input row_t r, input logic v);
    if (r.m < 4'h2) ctrl[r.s] = v;
    else if (r.m == MODE_INDEX) idx = v;
    else prb = v;
  endtask : pin
  task automatic wait_done;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk);
    chk_flags(st, 16'h0010);
    tick(2);
  endtask : wait_done
  task automatic run(input row_t r);
    mode = r.m;
    sel = r.s;
    pin(r, r.lv);
    tick(12);
    exe = 1'b1;
    tick(12);
    chk_flags(st, 16'h000C);
    pin(r, !r.lv);
    wait_done();
    chk_pos(pos, scale(r.m < 4'h2 ? ext : mot));
    exe = 1'b0;
    tick(12);
    chk_flags(st, 16'h0000);
    chk_pos(pos, scale(r.m < 4'h2 ? ext : mot));
    $display("capture mode %0h finished", r.m);
  endtask : run
  task automatic hit(input logic [3:0] m, input logic p, input logic [1:0] a,
    input logic [15:0] es, input logic [15:0] ef);
    mode = m;
    exe = 1'b1;
    tick(12);
    pre = p;
    alm = a[0];
    off = a[1];
    tick(12);
    chk_flags(st, es);
    if (es[0]) chk_flags(fault, ef);
    pre = 1'b0;
    alm = 1'b0;
    off = 1'b0;
    exe = 1'b0;
    tick(12);
    chk_flags(st, 16'h0000);
    $display("fault case mode %0h finished", m);
  endtask : hit
  // Execute dropped mid-capture; the closing flag lives one task period
  task automatic late(input logic p, input logic [15:0] es);
    exe = 1'b1;
    tick(12);
    exe = 1'b0;
    tick(8);
    chk_flags(st, 16'h000C);
    pre = p;
    prb = !p;
    for (int i = 0; i < 20 && st !== es; i++) @(negedge clk);
    chk_flags(st, es);
    pre = 1'b0;
    tick(4);
    chk_flags(st, 16'h0000);
    prb = 1'b0;
    tick(12);
    $display("late case %0h finished", es);
  endtask : late
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    tick(19);
    chk_flags(st, 16'h0000);
    chk_pos(pos, 64'h0);
    tick(1);
    nrst = 1'b1;
    // One capture at a time
    foreach (rows[i]) run(rows[i]);
    hit(4'h3, 1'b0, 2'b00, 16'h0001, FAULT_BAD_MODE);
    hit(MODE_DRV_RISE, 1'b0, 2'b01, 16'h0001, FAULT_AXIS_ALARM);
    hit(MODE_DRV_RISE, 1'b0, 2'b10, 16'h0001, FAULT_AXIS_OFFLINE);
    hit(MODE_DRV_RISE, 1'b1, 2'b00, 16'h0002, 16'h0000);
    late(1'b0, 16'h0010);
    late(1'b1, 16'h0002);
    prb = 1'b0;
    mode = MODE_DRV_BOTH;
    tick(12);
    exe = 1'b1;
    tick(12);
    prb = 1'b1;
    tick(12);
    mot = 32'h00000366;
    tick(12);
    prb = 1'b0;
    wait_done();
    chk_pos(pos, scale(32'h000001B3));
    chk_pos(tpos, scale(mot));
    exe = 1'b0;
    tick(12);
    $display("both edges finished");
    // Raw count passes its signed maximum before the capture
    mode = MODE_DRV_RISE;
    mot = 32'h7FFFFFFF;
    tick(4);
    mot = 32'h80000010;
    tick(12);
    exe = 1'b1;
    tick(12);
    prb = 1'b1;
    wait_done();
    chk_pos(pos, scale(mot));
    exe = 1'b0;
    tick(12);
    $display("count wrap finished");
    end_of_test();
  end
  // About sixteen times the expected run
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule : touch_probe_position_capture_tb
`default_nettype wire
